// File: touch_meas_params.svh
`ifndef TOUCH_MEAS_PARAMS_SVH
`define TOUCH_MEAS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define REG_RESOLUTION_OFF   8'h02
`define REG_AVERAGING_OFF    8'h03
`define REG_SAMPLING_OFF     8'h04
`define REG_PANEL_SETUP_OFF  8'h05
`define REG_DELAYED_CONV_OFF 8'h06
`define REG_RESET_VALUE      8'h00
`define REG_UNMAPPED_VALUE   8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RES_LOW_POWER_BIT    4
`define RES_USED_MASK        8'h1F
`define POSITION_NIBBLE_LSB  4
`define PRESSURE_NIBBLE_LSB  0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ               10000000
`define OSC_HZ               2000000
`define US_PER_S             1000000
`define ACQ_BASE_PERIODS     4
`define ADC_SETTLE_MIN_US    10
`define DELAY_US_01          20
`define DELAY_US_02          50
`define DELAY_US_03          80
`define DELAY_US_04          100
`define DELAY_US_05          200
`define DELAY_US_06          500
`define DELAY_US_07          800
`define DELAY_US_08          1000
`define DELAY_US_09          2000
`define DELAY_US_10          5000
`define DELAY_US_11          10000
`define DELAY_US_12          20000
`define DELAY_US_13          50000
`define DELAY_US_14          100000
`define DELAY_US_15          200000

`endif

// File: touch_meas_pkg.sv
package touch_meas_pkg;

    typedef enum logic [1:0] {
        MEAS_HORIZ,
        MEAS_VERT,
        MEAS_PRESSURE1,
        MEAS_PRESSURE2
    } meas_type_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_PANEL_SETUP,
        SEQ_ADC_SETTLE,
        SEQ_ACQUIRE,
        SEQ_CONVERT,
        SEQ_FINISH
    } seq_state_t;

endpackage

// File: interval_timer.sv
`timescale 1ns/10ps

module interval_timer #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_count,
    output logic              done
);

    logic [W-1:0] count;

    if (W < 2)
    begin : g_chk
        $error("interval_timer: W must be at least 2");
    end

    // done marks the last cycle of a loaded interval
    assign done = (count == W'(1));

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else if (clk_en)
        begin
            if (load)
                count <= load_count;
            else if (count != '0)
                count <= count - W'(1);
        end
    end

endmodule

// File: median_averager.sv
`timescale 1ns/10ps

module median_averager #(
    parameter int SAMPLE_W = 12,
    parameter int DEPTH    = 16
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    // samples
    input  wire logic                clear,
    input  wire logic                push,
    input  wire logic [SAMPLE_W-1:0] sample,
    // burst shape: sample count 1, 4, 8 or 16 and filter style
    input  wire logic [4:0]          burst_n,
    input  wire logic                mean_mode,
    output logic [SAMPLE_W-1:0]      average
);

    logic [SAMPLE_W-1:0] sorted [DEPTH];
    logic [4:0]          fill;

    if (DEPTH < 16 || SAMPLE_W < 8)
    begin : g_chk
        $error("median_averager: DEPTH >= 16 and SAMPLE_W >= 8 required");
    end

    function automatic logic [2:0] log2_of(input logic [4:0] n);
        case (n)
            5'h02:   log2_of = 3'h1;
            5'h04:   log2_of = 3'h2;
            5'h08:   log2_of = 3'h3;
            5'h10:   log2_of = 3'h4;
            default: log2_of = 3'h0;
        endcase
    endfunction

    // insertion sort as samples arrive, so the middle of the burst is ready at the end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fill <= '0;
            for (int i = 0; i < DEPTH; i++)
                sorted[i] <= '0;
        end
        else if (clk_en)
        begin
            if (clear)
                fill <= '0;
            else if (push && fill < 5'(DEPTH))
            begin
                fill <= fill + 5'h01;
                for (int i = 0; i < DEPTH; i++)
                begin
                    if (i < int'(fill) && sorted[i] > sample)
                        sorted[i] <= (i > 0 && sorted[(i > 0) ? i - 1 : 0] > sample)
                                     ? sorted[(i > 0) ? i - 1 : 0] : sample;
                    else if (i == int'(fill))
                        sorted[i] <= (i > 0 && sorted[(i > 0) ? i - 1 : 0] > sample)
                                     ? sorted[(i > 0) ? i - 1 : 0] : sample;
                end
            end
        end
    end

    // median style keeps the middle half, mean style keeps all
    always_comb
    begin
        logic [4:0]           lo;
        logic [4:0]           span;
        logic [SAMPLE_W+4:0]  sum;
        lo   = '0;
        span = '0;
        sum  = '0;
        if (burst_n <= 5'h01)
            span = 5'h01;
        else if (mean_mode)
            span = burst_n;
        else
        begin
            lo   = burst_n >> 2;
            span = burst_n >> 1;
        end
        for (int i = 0; i < DEPTH; i++)
            if (i >= int'(lo) && i < int'(lo) + int'(span))
                sum = sum + (SAMPLE_W+5)'(sorted[i]);
        average = SAMPLE_W'(sum >> log2_of(span));
    end

endmodule

// File: touch_measurement_config.sv
// Notes on behaviour
// - low-power bit 4 runs the ADC at reduced power and resolution
// - resolution bits 3:0 pick 12-bit (0) or 8-bit (1) for X,Y,Z1,Z2
// - averaging register: four 2-bit depth fields, each for its own type
// - median style: 1, or 4/8/16 samples averaging the middle half
// - mean style: 1, or 4/8/16 samples averaging all of them
// - operating-mode setting can enable or disable the averaging depths
// - sampling-time register: four 2-bit acquisition fields X,Y,Z1,Z2
// - acquisition codes give 4, 16, 64, 256 oscillator periods
// - acquire for the selected time before every conversion
// - panel setup register: position delay bits 7:4, pressure bits 3:0
// - panel setup code 0000 skips; others 20us up to 200ms
// - panel held in measurement set-up with ADC off during panel setup
// - delayed-conversion register: position bits 7:4, pressure bits 3:0
// - delayed-conversion codes 10us up to 200ms, same stepped table
// - during delayed conversion panel stays set up and ADC is powered
`timescale 1ns/10ps
`include "touch_meas_params.svh"

module touch_measurement_config
    import touch_meas_pkg::*;
#(
    parameter int US_CYCLES = `CLK_HZ / `US_PER_S,
    parameter int SAMPLE_W  = 12,
    parameter int TMR_W     = 24
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    // register port
    input  wire logic                reg_wr_en,
    input  wire logic                reg_rd_en,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wr_data,
    output logic      [7:0]          reg_rd_data,
    // operating mode settings held elsewhere
    input  wire logic                avg_enable,
    input  wire logic                mean_filter_select,
    // measurement request
    input  wire logic                meas_start,
    input  wire logic [1:0]          meas_type,
    // panel switches and ADC
    output logic                     panel_drive_en,
    output logic                     adc_power_en,
    output logic                     adc_low_power_select,
    output logic                     adc_width_8bit,
    output logic                     adc_acquire,
    output logic                     adc_convert_start,
    input  wire logic                adc_done,
    input  wire logic [SAMPLE_W-1:0] adc_result,
    // result
    output logic                     result_valid,
    output logic [SAMPLE_W-1:0]      result_data,
    output logic [1:0]               result_type,
    output logic                     busy
);

    localparam int OSC_DIV = `CLK_HZ / `OSC_HZ;

    if (US_CYCLES < 1 || US_CYCLES * `DELAY_US_15 >= (1 << (TMR_W - 1)) || OSC_DIV < 1)
    begin : g_chk
        $error("touch_measurement_config: timer too narrow for US_CYCLES");
    end

    // ----------------------------------------------------------------
    // lookups
    // ----------------------------------------------------------------
    function automatic logic [17:0] delay_us(input logic [3:0] code, input logic adc_on);
        case (code)
            4'h0:    delay_us = adc_on ? 18'(`ADC_SETTLE_MIN_US) : 18'h0;
            4'h1:    delay_us = 18'(`DELAY_US_01);
            4'h2:    delay_us = 18'(`DELAY_US_02);
            4'h3:    delay_us = 18'(`DELAY_US_03);
            4'h4:    delay_us = 18'(`DELAY_US_04);
            4'h5:    delay_us = 18'(`DELAY_US_05);
            4'h6:    delay_us = 18'(`DELAY_US_06);
            4'h7:    delay_us = 18'(`DELAY_US_07);
            4'h8:    delay_us = 18'(`DELAY_US_08);
            4'h9:    delay_us = 18'(`DELAY_US_09);
            4'hA:    delay_us = 18'(`DELAY_US_10);
            4'hB:    delay_us = 18'(`DELAY_US_11);
            4'hC:    delay_us = 18'(`DELAY_US_12);
            4'hD:    delay_us = 18'(`DELAY_US_13);
            4'hE:    delay_us = 18'(`DELAY_US_14);
            default: delay_us = 18'(`DELAY_US_15);
        endcase
    endfunction

    function automatic logic [TMR_W-1:0] us_to_cycles(input logic [17:0] us);
        us_to_cycles = TMR_W'(us * US_CYCLES);
    endfunction

    // X field sits highest, Z2 lowest
    function automatic logic [1:0] type_field(input logic [7:0] r, input logic [1:0] t);
        type_field = r[{~t, 1'b0} +: 2];
    endfunction

    function automatic logic [3:0] kind_nibble(input logic [7:0] r, input logic [1:0] t);
        kind_nibble = (t[1] == 1'b0) ? r[`POSITION_NIBBLE_LSB +: 4]
                                     : r[`PRESSURE_NIBBLE_LSB +: 4];
    endfunction

    function automatic logic [TMR_W-1:0] acq_cycles(input logic [1:0] code);
        acq_cycles = TMR_W'((`ACQ_BASE_PERIODS << {code, 1'b0}) * OSC_DIV);
    endfunction

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [7:0] res_cfg;
    logic [7:0] avg_cfg;
    logic [7:0] acq_cfg;
    logic [7:0] psu_cfg;
    logic [7:0] dcv_cfg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            res_cfg <= `REG_RESET_VALUE;
            avg_cfg <= `REG_RESET_VALUE;
            acq_cfg <= `REG_RESET_VALUE;
            psu_cfg <= `REG_RESET_VALUE;
            dcv_cfg <= `REG_RESET_VALUE;
        end
        else if (clk_en && reg_wr_en)
        begin
            case (reg_addr)
                `REG_RESOLUTION_OFF:   res_cfg <= reg_wr_data & `RES_USED_MASK;
                `REG_AVERAGING_OFF:    avg_cfg <= reg_wr_data;
                `REG_SAMPLING_OFF:     acq_cfg <= reg_wr_data;
                `REG_PANEL_SETUP_OFF:  psu_cfg <= reg_wr_data;
                `REG_DELAYED_CONV_OFF: dcv_cfg <= reg_wr_data;
                default:               ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rd_data <= `REG_UNMAPPED_VALUE;
        else if (clk_en && reg_rd_en)
        begin
            case (reg_addr)
                `REG_RESOLUTION_OFF:   reg_rd_data <= res_cfg;
                `REG_AVERAGING_OFF:    reg_rd_data <= avg_cfg;
                `REG_SAMPLING_OFF:     reg_rd_data <= acq_cfg;
                `REG_PANEL_SETUP_OFF:  reg_rd_data <= psu_cfg;
                `REG_DELAYED_CONV_OFF: reg_rd_data <= dcv_cfg;
                default:               reg_rd_data <= `REG_UNMAPPED_VALUE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // measurement sequencer
    // ----------------------------------------------------------------
    seq_state_t       state;
    seq_state_t       next_state;
    logic [1:0]       cur_type;
    logic [1:0]       sel_type;
    logic [4:0]       cur_burst;
    logic             cur_mean;
    logic [4:0]       taken;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_count;
    logic             tmr_done;
    logic             start_ok;
    logic [4:0]       next_burst;
    logic [SAMPLE_W-1:0] avg_out;

    assign sel_type = (state == SEQ_IDLE) ? meas_type : cur_type;
    assign start_ok = (state == SEQ_IDLE) && meas_start;

    // depth 00 and a disabled averaging setting both give one sample
    always_comb
    begin
        logic [1:0] depth;
        depth = type_field(avg_cfg, sel_type);
        if (!avg_enable || depth == 2'b00)
            next_burst = 5'h01;
        else
            next_burst = 5'h02 << depth;
    end

    always_comb
    begin
        next_state = state;
        case (state)
            SEQ_IDLE:
                if (meas_start)
                    next_state = (kind_nibble(psu_cfg, sel_type) == 4'h0)
                                 ? SEQ_ADC_SETTLE : SEQ_PANEL_SETUP;
            SEQ_PANEL_SETUP:
                if (tmr_done)
                    next_state = SEQ_ADC_SETTLE;
            SEQ_ADC_SETTLE:
                if (tmr_done)
                    next_state = SEQ_ACQUIRE;
            SEQ_ACQUIRE:
                if (tmr_done)
                    next_state = SEQ_CONVERT;
            SEQ_CONVERT:
                if (adc_done)
                    next_state = (taken + 5'h01 >= cur_burst) ? SEQ_FINISH : SEQ_ACQUIRE;
            SEQ_FINISH:
                next_state = SEQ_IDLE;
            default:
                next_state = SEQ_IDLE;
        endcase
    end

    // every timed phase loads the timer as it is entered
    always_comb
    begin
        tmr_load  = clk_en && (next_state != state || state == SEQ_CONVERT);
        tmr_count = TMR_W'(1);
        case (next_state)
            SEQ_PANEL_SETUP: tmr_count = us_to_cycles(delay_us(kind_nibble(psu_cfg, sel_type), 1'b0));
            SEQ_ADC_SETTLE:  tmr_count = us_to_cycles(delay_us(kind_nibble(dcv_cfg, sel_type), 1'b1));
            SEQ_ACQUIRE:     tmr_count = acq_cycles(type_field(acq_cfg, sel_type));
            default:         tmr_load  = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= SEQ_IDLE;
        else if (clk_en)
            state <= next_state;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur_type  <= 2'b00;
            cur_burst <= 5'h01;
            cur_mean  <= 1'b0;
        end
        else if (clk_en && start_ok)
        begin
            cur_type  <= meas_type;
            cur_burst <= next_burst;
            cur_mean  <= mean_filter_select;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            taken <= '0;
        else if (clk_en)
        begin
            if (start_ok)
                taken <= '0;
            else if (state == SEQ_CONVERT && adc_done)
                taken <= taken + 5'h01;
        end
    end

    interval_timer #(
        .W (TMR_W)
    ) u_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .load       (tmr_load),
        .load_count (tmr_count),
        .done       (tmr_done)
    );

    median_averager #(
        .SAMPLE_W (SAMPLE_W),
        .DEPTH    (16)
    ) u_avg (
        .clk       (clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .clear     (start_ok),
        .push      (state == SEQ_CONVERT && adc_done),
        .sample    (adc_result),
        .burst_n   (cur_burst),
        .mean_mode (cur_mean),
        .average   (avg_out)
    );

    // ----------------------------------------------------------------
    // panel and ADC controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            panel_drive_en    <= 1'b0;
            adc_power_en      <= 1'b0;
            adc_acquire       <= 1'b0;
            adc_convert_start <= 1'b0;
            adc_width_8bit    <= 1'b0;
            busy              <= 1'b0;
        end
        else if (clk_en)
        begin
            panel_drive_en    <= next_state inside {SEQ_PANEL_SETUP, SEQ_ADC_SETTLE,
                                                    SEQ_ACQUIRE, SEQ_CONVERT};
            adc_power_en      <= next_state inside {SEQ_ADC_SETTLE, SEQ_ACQUIRE,
                                                    SEQ_CONVERT};
            adc_acquire       <= (next_state == SEQ_ACQUIRE);
            adc_convert_start <= (next_state == SEQ_CONVERT) && (state != SEQ_CONVERT);
            adc_width_8bit    <= res_cfg[~sel_type];
            busy              <= (next_state != SEQ_IDLE);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            adc_low_power_select <= 1'b0;
        else if (clk_en)
            adc_low_power_select <= res_cfg[`RES_LOW_POWER_BIT];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result_valid <= 1'b0;
            result_data  <= '0;
            result_type  <= 2'b00;
        end
        else if (clk_en)
        begin
            result_valid <= (state == SEQ_FINISH);
            if (state == SEQ_FINISH)
            begin
                result_data <= avg_out;
                result_type <= cur_type;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [TMR_W-1:0] phase_len;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            phase_len <= '0;
        else if (clk_en)
            phase_len <= (next_state != state) ? '0 : phase_len + TMR_W'(1);
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_panel_phase;
        state == SEQ_PANEL_SETUP && clk_en && next_state != SEQ_PANEL_SETUP;
    endsequence

    sequence s_settle_phase;
        state == SEQ_ADC_SETTLE;
    endsequence

    a_setup_adc_off: assert property (state == SEQ_PANEL_SETUP |-> panel_drive_en && !adc_power_en)
        else $error("panel setup with ADC powered");
    a_settle_adc_on: assert property (s_settle_phase |-> panel_drive_en && adc_power_en)
        else $error("delayed conversion without panel or ADC");
    a_setup_order: assert property (s_panel_phase |=> s_settle_phase)
        else $error("panel setup not followed by delayed conversion");
    a_skip_setup: assert property (start_ok && clk_en && kind_nibble(psu_cfg, meas_type) == 4'h0
        |=> state == SEQ_ADC_SETTLE && phase_len == '0)
        else $error("zero setup code did not skip");
    a_settle_len: assert property (state == SEQ_ADC_SETTLE && clk_en && next_state != state
        |-> phase_len + TMR_W'(1) == us_to_cycles(delay_us(kind_nibble(dcv_cfg, cur_type), 1'b1)))
        else $error("delayed conversion length wrong");
    a_acq_len: assert property (state == SEQ_ACQUIRE && clk_en && next_state != state
        |-> phase_len + TMR_W'(1) == acq_cycles(type_field(acq_cfg, cur_type)))
        else $error("acquisition length wrong");
    a_acq_first: assert property ($rose(adc_convert_start) |-> $past(state == SEQ_ACQUIRE))
        else $error("conversion started without acquisition");
    a_burst_count: assert property (state == SEQ_FINISH |-> taken == cur_burst)
        else $error("burst sample count wrong");
    a_avg_disable: assert property (start_ok && clk_en && !avg_enable |=> cur_burst == 5'h01)
        else $error("averaging not disabled");
    a_low_power: assert property (clk_en |=> adc_low_power_select == $past(res_cfg[`RES_LOW_POWER_BIT]))
        else $error("low power select does not follow register");

endmodule

// File: adc_model.sv
`timescale 1ns/10ps

module adc_model (
    // clock
    input  wire logic        clk,
    // adc control from the block
    input  wire logic        adc_power_en,
    input  wire logic        adc_convert_start,
    // conversion answer
    output logic             adc_done,
    output logic [11:0]      adc_result
);
    int          wait_n = 0;
    int          k = 0;
    int          off[4] = '{0, 40, 4, 8};
    logic [11:0] v = 12'h100;
    initial adc_done = 1'b0;
    initial adc_result = 12'hEFF;
    // result only valid with done; otherwise inverse of last value
    always @(posedge clk)
    begin
        #1;
        if (adc_done)
        begin
            adc_done = 1'b0;
            adc_result = ~v;
        end
        if (!adc_power_en) k = 0;
        if (adc_convert_start) wait_n = 3;
        else if (wait_n > 0)
        begin
            wait_n--;
            if (wait_n == 0)
            begin
                v = 12'h100 + 12'(off[k % 4]);
                k++;
                adc_done = 1'b1;
                adc_result = v;
            end
        end
    end
endmodule

// File: test_touch_measurement_config.sv
`timescale 1ns/10ps

module test_touch_measurement_config;
    logic clk = 0, reset_n = 0, wr = 0, rd = 0, avg_en = 1, mean = 0, start = 0;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [1:0] mtype = 0, rtype;
    logic panel, power, lowp, w8, acq, conv, done, rvalid, busy;
    logic [11:0] ares, rdat;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    touch_measurement_config #(.US_CYCLES(1)) touch_measurement_config_inst (.clk(clk),
        .reset_n(reset_n), .clk_en(1'b1), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
        .reg_wr_data(wdata), .reg_rd_data(rdata), .avg_enable(avg_en),
        .mean_filter_select(mean), .meas_start(start), .meas_type(mtype),
        .panel_drive_en(panel), .adc_power_en(power), .adc_low_power_select(lowp),
        .adc_width_8bit(w8), .adc_acquire(acq), .adc_convert_start(conv), .adc_done(done),
        .adc_result(ares), .result_valid(rvalid), .result_data(rdat), .result_type(rtype),
        .busy(busy));
    adc_model adc_model_inst (.clk(clk), .adc_power_en(power), .adc_convert_start(conv),
        .adc_done(done), .adc_result(ares));
    task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1 {wr, addr, wdata} = {1'b1, a, d};
        @(posedge clk) #1 wr = 0;
    endtask
    task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
        @(posedge clk) #1 {rd, addr} = {1'b1, a};
        @(posedge clk) #1 rd = 0;
        chk("reg_rd_data", {4'h0, exp}, {4'h0, rdata});
    endtask
    // reset values, stored bits, unmapped offset
    task automatic reg_test;
        for (int a = 2; a < 7; a++) rd_reg(8'(a), 8'h00);
        for (int a = 2; a < 8; a++) wr_reg(8'(a), 8'hFF);
        rd_reg(8'h02, 8'h1F);
        for (int a = 3; a < 7; a++) rd_reg(8'(a), 8'hFF);
        rd_reg(8'h07, 8'h00);
    endtask
    // one measurement: phase lengths, width select, result
    task automatic meas(logic [1:0] t, int n_su, int n_st, int n_aq, logic [11:0] exp,
                        logic exp_w8, int n_cv);
        int su = 0, st = 0, aq = 0, cv = 0;
        bit seen = 0;
        @(posedge clk) #1 {start, mtype} = {1'b1, t};
        @(posedge clk) #1 start = 0;
        for (int i = 0; i < 4000 && !rvalid; i++)
        begin
            if (panel && !power) su++;
            if (conv) cv++;
            if (power && !panel) chk("adc_power_en", 0, 1);
            if (acq)
            begin
                seen = 1;
                aq++;
                if (w8 !== exp_w8) chk("adc_width_8bit", 12'(exp_w8), 12'(w8));
            end
            if (power && !acq && !seen) st++;
            @(posedge clk) #1;
        end
        chk("setup cycles", 12'(n_su), 12'(su));
        chk("settle cycles", 12'(n_st), 12'(st));
        chk("acquire cycles", 12'(n_aq), 12'(aq));
        chk("convert pulses", 12'(n_cv), 12'(cv));
        chk("result_data", exp, rdat);
        chk("result_type", 12'(t), 12'(rtype));
        chk("busy", 0, 12'(busy));
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        #1 reset_n = 1;
        reg_test();
        wr_reg(8'h02, 8'h04);
        @(posedge clk) #1 chk("adc_low_power_select", 0, 12'(lowp));
        wr_reg(8'h02, 8'h14);
        @(posedge clk) #1 chk("adc_low_power_select", 1, 12'(lowp));
        wr_reg(8'h03, 8'h17);
        wr_reg(8'h04, 8'h1B);
        wr_reg(8'h05, 8'h12);
        wr_reg(8'h06, 8'h10);
        meas(2'd0, 20, 20, 20, 12'h100, 0, 1);
        meas(2'd1, 20, 20, 320, 12'h106, 1, 4);
        mean = 1;
        meas(2'd2, 50, 10, 1280, 12'h10D, 0, 4);
        avg_en = 0;
        meas(2'd3, 50, 10, 1280, 12'h100, 0, 1);
        avg_en = 1;
        mean = 0;
        wr_reg(8'h03, 8'h97);
        wr_reg(8'h05, 8'h02);
        meas(2'd0, 0, 20, 160, 12'h106, 0, 8);
        results();
    end
endmodule
